/* src/ssr_register_file.sv */
// register file controlling and watching the secure-session core
`timescale 1ns/1ps
// Notes on behaviour
// R1 - offload window below 0x100, core window above
// R2 - write: one-cycle strobe, word address, lane enables
// R3 - read: request, answer with read-valid and data
// R4 - bridge crosses clocks; registers see 32-bit strobes
// R5 - offset 0x100 bit 0 drives core reset low
// R6 - offset 0x104 returns handshake and transfer busy
// R7 - offset 0x108 returns 16-bit alert code
// R8 - offset 0x10C loads 16-bit response timeout
// R9 - offset 0x110 returns transmit ring read pointer
// R10 - offset 0x114 loads transmit ring write pointer
// R11 - offset 0x118 loads receive ring read pointer
// R12 - offset 0x11C returns receive ring write pointer
// R13 - offset 0x120 sets generator pattern select
// R14 - offset 0x124 writes length, reads remaining
// R15 - offset 0x128 reads checker busy and mismatch
// R16 - offset 0x128 write sets checker pattern select
// R17 - offset 0x12C writes length, reads remaining
// R18 - offset 0x130 loads header skip byte count
// R19 - address bits 13 to 2 pick the register
// R20 - read-valid two cycles after read request
// R21 - unmapped writes ignored, unmapped reads return zero
module ssr_register_file (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                rstn,
  // register strobe interface from the bridge
  input  wire ssr_pkg::ssr_req_t   req,  // see R4
  output logic                     reg_read_valid,
  output logic              [31:0] reg_read_word,
  // access falls in the offload engine window
  output logic                     offload_area_select,
  // core side
  input  wire ssr_pkg::ssr_status_t status,
  output ssr_pkg::ssr_ctrl_t        ctrl
);
  import ssr_pkg::*;

  // start-pulse state held directly in this module; stored fields sit in the lane registers
  typedef struct packed {
    logic generator_start;
    logic checker_start;
  } ssr_rf_st_t;

  ssr_rf_st_t st_ff;   // registered state
  ssr_rf_st_t nxt_st;  // next state

  // decode helpers
  logic [17:0] addr;          // byte address of this access
  logic [11:0] reg_index;     // word index inside an area
  logic        in_offload;    // address in offload window
  logic        in_secure;     // address in core window
  logic        in_reg_area;   // core window, register area
  logic        wr_hit;        // write aimed at our registers
  logic        rd_hit;        // read aimed at our registers

  // per-register write loads
  logic ld_core_reset;
  logic ld_timeout;
  logic ld_tx_wr_ptr;
  logic ld_rx_rd_ptr;
  logic ld_gen_type;
  logic ld_gen_length;
  logic ld_chk_mode;
  logic ld_chk_length;
  logic ld_header_skip;

  // stored fields from the lane registers
  logic [0:0]  core_reset_q;
  logic [15:0] timeout_q;
  logic [13:0] tx_wr_ptr_q;
  logic [13:0] rx_rd_ptr_q;
  logic [1:0]  gen_type_q;
  logic [31:0] gen_length_q;
  logic [1:0]  chk_mode_q;
  logic [31:0] chk_length_q;
  logic [13:0] header_skip_q;

  // read mux output and its mapped flag
  logic [31:0] select_word;
  logic        rd_mapped;

  // index of a register offset, bits 13 down to 2
  function automatic logic [11:0] index_of(input logic [17:0] off);
    index_of = off[13:2];
  endfunction

  // address windows and area select
  always_comb begin
    addr        = req.reg_word_address;
    reg_index   = addr[13:2];                      // see R19
    in_offload  = (addr <= OFFLOAD_LAST);          // see R1
    in_secure   = (addr >= SECURE_FIRST) &&
                  (addr <= SECURE_LAST);           // see R1
    in_reg_area = in_secure &&
                  (addr[17:16] == REG_AREA_SEL);
    wr_hit      = req.reg_write_strobe && in_reg_area;  // see R2
    rd_hit      = req.reg_read_request && in_reg_area;  // see R3
  end

  // offload accesses are passed on, not answered here
  assign offload_area_select = in_offload &&
    (req.reg_write_strobe || req.reg_read_request);     // see R1

  // write decode; other offsets are simply dropped
  always_comb begin
    ld_core_reset  = wr_hit && (reg_index == index_of(OFF_CORE_RESET));
    ld_timeout     = wr_hit && (reg_index == index_of(OFF_TIMEOUT));
    ld_tx_wr_ptr   = wr_hit && (reg_index == index_of(OFF_TX_WR_PTR));
    ld_rx_rd_ptr   = wr_hit && (reg_index == index_of(OFF_RX_RD_PTR));
    ld_gen_type    = wr_hit && (reg_index == index_of(OFF_GEN_TYPE));
    ld_gen_length  = wr_hit && (reg_index == index_of(OFF_GEN_LENGTH));
    ld_chk_mode    = wr_hit && (reg_index == index_of(OFF_CHK_MODE));
    ld_chk_length  = wr_hit && (reg_index == index_of(OFF_CHK_LENGTH));
    ld_header_skip = wr_hit &&
                     (reg_index == index_of(OFF_HEADER_SKIP)); // see R21
  end

  // core reset, held low until software writes 1
  ssr_lane_reg #(.WIDTH(1), .RESET_VALUE(RST_CORE_RESET)) u_core_reset (
    .clk          (clk),
    .rstn         (rstn),
    .load         (ld_core_reset),                   // see R5
    .lane_enables (req.reg_byte_lane_enables),
    .write_word   (req.reg_write_word),
    .value        (core_reset_q)
  );

  // response timeout
  ssr_lane_reg #(.WIDTH(16), .RESET_VALUE(RST_TIMEOUT)) u_timeout (
    .clk          (clk),
    .rstn         (rstn),
    .load         (ld_timeout),                      // see R8
    .lane_enables (req.reg_byte_lane_enables),
    .write_word   (req.reg_write_word),
    .value        (timeout_q)
  );

  // transmit ring write pointer
  ssr_lane_reg #(.WIDTH(14), .RESET_VALUE(RST_POINTER)) u_tx_wr_ptr (
    .clk          (clk),
    .rstn         (rstn),
    .load         (ld_tx_wr_ptr),                    // see R10
    .lane_enables (req.reg_byte_lane_enables),
    .write_word   (req.reg_write_word),
    .value        (tx_wr_ptr_q)
  );

  // receive ring read pointer
  ssr_lane_reg #(.WIDTH(14), .RESET_VALUE(RST_POINTER)) u_rx_rd_ptr (
    .clk          (clk),
    .rstn         (rstn),
    .load         (ld_rx_rd_ptr),                    // see R11
    .lane_enables (req.reg_byte_lane_enables),
    .write_word   (req.reg_write_word),
    .value        (rx_rd_ptr_q)
  );

  // generator pattern select
  ssr_lane_reg #(.WIDTH(2), .RESET_VALUE(RST_PATTERN)) u_gen_type (
    .clk          (clk),
    .rstn         (rstn),
    .load         (ld_gen_type),                     // see R13
    .lane_enables (req.reg_byte_lane_enables),
    .write_word   (req.reg_write_word),
    .value        (gen_type_q)
  );

  // generator length
  ssr_lane_reg #(.WIDTH(32), .RESET_VALUE(RST_LENGTH)) u_gen_length (
    .clk          (clk),
    .rstn         (rstn),
    .load         (ld_gen_length),                   // see R14
    .lane_enables (req.reg_byte_lane_enables),
    .write_word   (req.reg_write_word),
    .value        (gen_length_q)
  );

  // checker pattern select, two bits at the bottom
  ssr_lane_reg #(.WIDTH(2), .RESET_VALUE(RST_PATTERN)) u_chk_mode (
    .clk          (clk),
    .rstn         (rstn),
    .load         (ld_chk_mode),                     // see R16
    .lane_enables (req.reg_byte_lane_enables),
    .write_word   (req.reg_write_word),
    .value        (chk_mode_q)
  );

  // checker length
  ssr_lane_reg #(.WIDTH(32), .RESET_VALUE(RST_LENGTH)) u_chk_length (
    .clk          (clk),
    .rstn         (rstn),
    .load         (ld_chk_length),                   // see R17
    .lane_enables (req.reg_byte_lane_enables),
    .write_word   (req.reg_write_word),
    .value        (chk_length_q)
  );

  // header skip byte count
  ssr_lane_reg #(.WIDTH(14), .RESET_VALUE(RST_LENGTH)) u_header_skip (
    .clk          (clk),
    .rstn         (rstn),
    .load         (ld_header_skip),                  // see R18
    .lane_enables (req.reg_byte_lane_enables),
    .write_word   (req.reg_write_word),
    .value        (header_skip_q)
  );

  // start pulses follow a length write by one cycle
  always_comb begin
    nxt_st                 = st_ff;
    nxt_st.generator_start = ld_gen_length;          // see R14
    nxt_st.checker_start   = ld_chk_length;          // see R17
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // control bundle to the core
  always_comb begin
    ctrl.secure_core_reset_n      = core_reset_q[0];    // see R5
    ctrl.response_timeout         = timeout_q;
    ctrl.tx_ring_write_pointer    = tx_wr_ptr_q;
    ctrl.rx_ring_read_pointer     = rx_rd_ptr_q;
    ctrl.generator_pattern_select = ssr_pattern_t'(gen_type_q);
    ctrl.generator_length         = gen_length_q;
    ctrl.generator_start          = st_ff.generator_start;
    ctrl.checker_pattern_select   = ssr_pattern_t'(chk_mode_q);
    ctrl.checker_length           = chk_length_q;
    ctrl.checker_start            = st_ff.checker_start;
    ctrl.header_skip_length       = header_skip_q;
  end

  // read mux; write-only and unmapped words read zero
  always_comb begin
    select_word = 32'h0000_0000;
    rd_mapped   = 1'b1;
    unique case (reg_index)
      index_of(OFF_CORE_BUSY): begin                   // see R6
        select_word[BUSY_HANDSHAKE_BIT] = status.handshake_busy;
        select_word[BUSY_TRANSFER_BIT]  = status.transfer_busy;
      end
      index_of(OFF_ALERT_CODE): begin                  // see R7
        select_word[15:0] = status.alert_code;
      end
      index_of(OFF_TX_RD_PTR): begin                   // see R9
        select_word[13:0] = status.tx_ring_read_pointer;
      end
      index_of(OFF_RX_WR_PTR): begin                   // see R12
        select_word[13:0] = status.rx_ring_write_pointer;
      end
      index_of(OFF_GEN_LENGTH): begin                  // see R14
        select_word = status.generator_remaining;
      end
      index_of(OFF_CHK_MODE): begin                    // see R15
        select_word[CHK_BUSY_BIT]     = status.checker_busy;
        select_word[CHK_MISMATCH_BIT] = status.checker_mismatch;
      end
      index_of(OFF_CHK_LENGTH): begin                  // see R17
        select_word = status.checker_remaining;
      end
      default: begin                                   // see R21
        rd_mapped = 1'b0;
      end
    endcase
  end

  // answer path: read-valid two edges after the request
  ssr_read_pipe u_read_pipe (
    .clk         (clk),
    .rstn        (rstn),
    .request     (rd_hit),                             // see R20
    .select_word (select_word),
    .read_valid  (reg_read_valid),
    .read_word   (reg_read_word)
  );

  // read answered at the promised latency
  read_latency_a: assert property ( // see R20
    @(posedge clk) disable iff (!rstn)
    rd_hit |-> ##2 reg_read_valid)
    else $error("read-valid not two cycles after request");

  // no answer without a request two cycles before
  valid_cause_a: assert property ( // see R3
    @(posedge clk) disable iff (!rstn)
    reg_read_valid |-> $past(rd_hit, 2))
    else $error("read-valid without a request");

  // core reset follows bit 0 of its write
  core_reset_a: assert property ( // see R5
    @(posedge clk) disable iff (!rstn)
    ld_core_reset && req.reg_byte_lane_enables[0]
    |=> ctrl.secure_core_reset_n == $past(req.reg_write_word[0]))
    else $error("core reset not loaded from bit 0");

  // timeout loaded from the low half word
  timeout_load_a: assert property ( // see R8
    @(posedge clk) disable iff (!rstn)
    ld_timeout && (req.reg_byte_lane_enables[1:0] == 2'h3)
    |=> ctrl.response_timeout == $past(req.reg_write_word[15:0]))
    else $error("timeout not loaded");

  // disabled top lane keeps its byte
  lane_keep_a: assert property ( // see R2
    @(posedge clk) disable iff (!rstn)
    ld_gen_length && !req.reg_byte_lane_enables[3]
    |=> $stable(ctrl.generator_length[31:24]))
    else $error("disabled byte lane was written");

  // unmapped reads return zero
  unmapped_zero_a: assert property ( // see R21
    @(posedge clk) disable iff (!rstn)
    rd_hit && !rd_mapped |-> ##2 reg_read_word == 32'h0000_0000)
    else $error("unmapped read returned nonzero");

  // offload accesses leave the stored fields alone
  // start pulses are left out: they may trail an earlier length write
  offload_route_a: assert property ( // see R1
    @(posedge clk) disable iff (!rstn)
    offload_area_select |=> $stable({ctrl.secure_core_reset_n,
      ctrl.response_timeout, ctrl.tx_ring_write_pointer,
      ctrl.rx_ring_read_pointer, ctrl.generator_pattern_select,
      ctrl.generator_length, ctrl.checker_pattern_select,
      ctrl.checker_length, ctrl.header_skip_length}))
    else $error("offload access changed core control");

  // busy word carries only two bits
  busy_bits_a: assert property ( // see R6
    @(posedge clk) disable iff (!rstn)
    rd_hit && (reg_index == index_of(OFF_CORE_BUSY))
    |-> ##2 reg_read_word[31:2] == 30'h0)
    else $error("busy read has stray bits");

  // start pulse high exactly in the cycle after a length write
  gen_start_a: assert property ( // see R14
    @(posedge clk) disable iff (!rstn)
    ctrl.generator_start == $past(ld_gen_length))
    else $error("generator start pulse wrong");

endmodule // ssr_register_file

/* inc/ssr_pkg.sv */
// constants and carrier types for the secure-session register file
package ssr_pkg;

  // byte address width seen on the register strobe interface
  localparam int ADDR_W = 18;
  // cycles from an accepted read request to read-valid
  localparam int READ_LATENCY = 2;

  // address windows of the two register areas
  localparam logic [17:0] OFFLOAD_LAST  = 18'h000FF;
  localparam logic [17:0] SECURE_FIRST  = 18'h00100;
  localparam logic [17:0] SECURE_LAST   = 18'h3FFFF;
  // upper address bits that pick the internal register area
  localparam logic [1:0]  REG_AREA_SEL  = 2'h0;

  // register offsets (byte addresses)
  localparam logic [17:0] OFF_CORE_RESET   = 18'h00100;
  localparam logic [17:0] OFF_CORE_BUSY    = 18'h00104;
  localparam logic [17:0] OFF_ALERT_CODE   = 18'h00108;
  localparam logic [17:0] OFF_TIMEOUT      = 18'h0010C;
  localparam logic [17:0] OFF_TX_RD_PTR    = 18'h00110;
  localparam logic [17:0] OFF_TX_WR_PTR    = 18'h00114;
  localparam logic [17:0] OFF_RX_RD_PTR    = 18'h00118;
  localparam logic [17:0] OFF_RX_WR_PTR    = 18'h0011C;
  localparam logic [17:0] OFF_GEN_TYPE     = 18'h00120;
  localparam logic [17:0] OFF_GEN_LENGTH   = 18'h00124;
  localparam logic [17:0] OFF_CHK_MODE     = 18'h00128;
  localparam logic [17:0] OFF_CHK_LENGTH   = 18'h0012C;
  localparam logic [17:0] OFF_HEADER_SKIP  = 18'h00130;

  // field positions
  localparam int BUSY_HANDSHAKE_BIT = 1;
  localparam int BUSY_TRANSFER_BIT  = 0;
  localparam int CHK_BUSY_BIT       = 1;
  localparam int CHK_MISMATCH_BIT   = 0;

  // values after reset
  localparam logic [31:0] RST_CORE_RESET  = 32'h0000_0000;
  localparam logic [31:0] RST_TIMEOUT     = 32'h0000_0000;
  localparam logic [31:0] RST_POINTER     = 32'h0000_0000;
  localparam logic [31:0] RST_PATTERN     = 32'h0000_0000;
  localparam logic [31:0] RST_LENGTH      = 32'h0000_0000;

  // pattern encodings shared by generator and checker
  typedef enum logic [1:0] {
    PATT_DEC_BIN  = 2'h0,
    PATT_INC_BIN  = 2'h1,
    PATT_DEC_TEXT = 2'h2,
    PATT_INC_TEXT = 2'h3
  } ssr_pattern_t;

  // one register access from the bridge
  typedef struct packed {
    logic        reg_write_strobe;
    logic        reg_read_request;
    logic [17:0] reg_word_address;
    logic [31:0] reg_write_word;
    logic [3:0]  reg_byte_lane_enables;
  } ssr_req_t;

  // status coming back from the core and its helpers
  typedef struct packed {
    logic        handshake_busy;
    logic        transfer_busy;
    logic [15:0] alert_code;
    logic [13:0] tx_ring_read_pointer;
    logic [13:0] rx_ring_write_pointer;
    logic [31:0] generator_remaining;
    logic        checker_busy;
    logic        checker_mismatch;
    logic [31:0] checker_remaining;
  } ssr_status_t;

  // control driven to the core and its helpers
  typedef struct packed {
    logic         secure_core_reset_n;
    logic [15:0]  response_timeout;
    logic [13:0]  tx_ring_write_pointer;
    logic [13:0]  rx_ring_read_pointer;
    ssr_pattern_t generator_pattern_select;
    logic [31:0]  generator_length;
    logic         generator_start;
    ssr_pattern_t checker_pattern_select;
    logic [31:0]  checker_length;
    logic         checker_start;
    logic [13:0]  header_skip_length;
  } ssr_ctrl_t;

endpackage

/* src/ssr_lane_reg.sv */
// write-only register with byte-lane enables
`timescale 1ns/1ps
module ssr_lane_reg #(
  parameter int          WIDTH       = 32,
  parameter logic [31:0] RESET_VALUE = 32'h0000_0000
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             rstn,
  // write side
  input  wire logic             load,
  input  wire logic [3:0]       lane_enables,
  input  wire logic [31:0]      write_word,
  // stored value
  output logic      [WIDTH-1:0] value
);
  import ssr_pkg::*;

  // whole state of this register
  typedef struct packed {
    logic [WIDTH-1:0] value;
  } ssr_lane_st_t;

  ssr_lane_st_t st_ff;   // registered state
  ssr_lane_st_t nxt_st;  // next state

  // each bit follows its own byte lane enable
  always_comb begin
    nxt_st = st_ff;
    for (int b = 0; b < WIDTH; b++) begin
      if (load && lane_enables[b/8]) begin
        nxt_st.value[b] = write_word[b];
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff.value <= RESET_VALUE[WIDTH-1:0];
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign value = st_ff.value;

endmodule // ssr_lane_reg

/* src/ssr_read_pipe.sv */
// two-stage read return path
`timescale 1ns/1ps
module ssr_read_pipe (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // selected read data
  input  wire logic        request,
  input  wire logic [31:0] select_word,
  // answer to the bridge
  output logic             read_valid,
  output logic      [31:0] read_word
);
  import ssr_pkg::*;

  // whole state of the return path
  typedef struct packed {
    logic        stage_valid;
    logic [31:0] stage_word;
    logic        out_valid;
    logic [31:0] out_word;
  } ssr_pipe_st_t;

  ssr_pipe_st_t st_ff;   // registered state
  ssr_pipe_st_t nxt_st;  // next state

  // first stage captures the mux, second presents it
  always_comb begin
    nxt_st             = st_ff;
    nxt_st.stage_valid = request;
    nxt_st.stage_word  = request ? select_word : 32'h0000_0000;
    nxt_st.out_valid   = st_ff.stage_valid;
    nxt_st.out_word    = st_ff.stage_word;
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign read_valid = st_ff.out_valid;
  assign read_word  = st_ff.out_word;

endmodule // ssr_read_pipe

/* verification/ssr_host_model.sv */
// bridge-side master model issuing register strobes and read requests
`timescale 1ns/1ps
module ssr_host_model (
  // clock
  input  wire logic              clk,
  // answer from the register file
  input  wire logic              reg_read_valid,
  input  wire logic       [31:0] reg_read_word,
  input  wire logic              offload_area_select,
  // request towards the register file
  output ssr_pkg::ssr_req_t      req
);
  import ssr_pkg::*;

  // bus idle at time zero
  initial req = '0;

  // one-cycle write strobe; released fields show inverted junk
  task automatic wr(input logic [17:0] a, input logic [31:0] d,
                    input logic [3:0] l);
    @(posedge clk);
    #1;
    req = '{1'h1, 1'h0, a, d, l};
    @(posedge clk);
    #1;
    req = '{1'h0, 1'h0, ~a, ~d, ~l};
  endtask

  // read request, then wait for read-valid under a bound
  task automatic rd(input logic [17:0] a, output logic [31:0] d,
                    output int lat);
    @(posedge clk);
    #1;
    req = '{1'h0, 1'h1, a, 32'h0, 4'h0};
    @(posedge clk);
    #1;
    req = '{1'h0, 1'h0, ~a, 32'hFFFF_FFFF, 4'hF};
    lat = 1;
    while (reg_read_valid !== 1'h1 && lat < 8) begin
      @(posedge clk);
      #1;
      lat++;
    end
    d = reg_read_word;
  endtask

  // read request; reports the area flag and whether any answer came
  task automatic probe(input logic [17:0] a, output logic sel,
                       output logic got);
    @(posedge clk);
    #1;
    req = '{1'h0, 1'h1, a, 32'h0, 4'h0};
    #1;
    sel = offload_area_select;
    @(posedge clk);
    #1;
    req = '{1'h0, 1'h0, ~a, 32'hFFFF_FFFF, 4'hF};
    got = 1'h0;
    repeat (3) begin
      @(posedge clk);
      #1;
      got = got | (reg_read_valid === 1'h1);
    end
  endtask
endmodule // ssr_host_model

/* verification/tb.sv */
// self-checking bench for the secure-session register file
`timescale 1ns/1ps
module tb;
  import ssr_pkg::*;

  logic        clk;          // core clock
  logic        rstn;         // async reset, active low
  ssr_req_t    req;          // request from the host model
  ssr_status_t status;       // core status, random
  ssr_ctrl_t   ctrl;         // control from the register file
  ssr_ctrl_t   ex;           // expected control
  ssr_ctrl_t   got_c;        // control with start pulses cleared
  logic        rv;           // read-valid
  logic [31:0] rw;           // read word
  logic        sel_o;        // offload area flag
  logic [17:0] offs [15];    // address table
  logic [17:0] a;            // current address
  logic [31:0] d;            // current data
  logic [3:0]  l;            // current lanes
  logic        s;            // flag seen by probe
  logic        g;            // answer seen by probe
  int          lat;          // read latency seen
  int          num_errors;   // mismatches
  int          total_checks; // comparisons
  integer      seed;         // random seed

  // device under test
  ssr_register_file uut (.clk(clk), .rstn(rstn), .req(req),
    .reg_read_valid(rv), .reg_read_word(rw), .offload_area_select(sel_o),
    .status(status), .ctrl(ctrl));

  // bridge side
  ssr_host_model host (.clk(clk), .reg_read_valid(rv), .reg_read_word(rw),
    .offload_area_select(sel_o), .req(req));

  // 100 MHz clock
  always #5 clk = ~clk;

  // count and report one comparison
  task automatic check(input logic ok, input string msg);
    total_checks++;
    if (!ok) begin
      num_errors++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask

  // verdict and end of run
  task automatic report_and_stop;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // byte-lane merge of a new word into an old one
  function automatic logic [31:0] mg(logic [31:0] o, logic [31:0] n,
                                     logic [31:0] m);
    return (o & ~m) | (n & m);
  endfunction

  // expected control after a write; ignored outside mapped fields
  function automatic ssr_ctrl_t apply(ssr_ctrl_t c, logic [17:0] x,
                                      logic [31:0] w, logic [3:0] e);
    logic [31:0] m;
    m = {{8{e[3]}}, {8{e[2]}}, {8{e[1]}}, {8{e[0]}}};
    if (x[17:16] == 2'h0 && x > OFFLOAD_LAST) begin
      case (x[13:2])
        OFF_CORE_RESET[13:2]: if (e[0]) c.secure_core_reset_n = w[0];
        OFF_TIMEOUT[13:2]: c.response_timeout =
          16'(mg({16'h0, c.response_timeout}, w, m));
        OFF_TX_WR_PTR[13:2]: c.tx_ring_write_pointer =
          14'(mg({18'h0, c.tx_ring_write_pointer}, w, m));
        OFF_RX_RD_PTR[13:2]: c.rx_ring_read_pointer =
          14'(mg({18'h0, c.rx_ring_read_pointer}, w, m));
        OFF_GEN_TYPE[13:2]: c.generator_pattern_select = ssr_pattern_t'(
          2'(mg({30'h0, c.generator_pattern_select}, w, m)));
        OFF_GEN_LENGTH[13:2]: c.generator_length =
          mg(c.generator_length, w, m);
        OFF_CHK_MODE[13:2]: c.checker_pattern_select = ssr_pattern_t'(
          2'(mg({30'h0, c.checker_pattern_select}, w, m)));
        OFF_CHK_LENGTH[13:2]: c.checker_length = mg(c.checker_length, w, m);
        OFF_HEADER_SKIP[13:2]: c.header_skip_length =
          14'(mg({18'h0, c.header_skip_length}, w, m));
        default: c = c;
      endcase
    end
    return c;
  endfunction

  // expected read word; zero for write-only and unmapped places
  function automatic logic [31:0] exp_rd(logic [17:0] x, ssr_status_t t);
    logic [31:0] r;
    r = 32'h0;
    if (x[17:16] == 2'h0 && x > OFFLOAD_LAST) begin
      case (x[13:2])
        OFF_CORE_BUSY[13:2]: r = {30'h0, t.handshake_busy, t.transfer_busy};
        OFF_ALERT_CODE[13:2]: r = {16'h0, t.alert_code};
        OFF_TX_RD_PTR[13:2]: r = {18'h0, t.tx_ring_read_pointer};
        OFF_RX_WR_PTR[13:2]: r = {18'h0, t.rx_ring_write_pointer};
        OFF_GEN_LENGTH[13:2]: r = t.generator_remaining;
        OFF_CHK_MODE[13:2]: r = {30'h0, t.checker_busy, t.checker_mismatch};
        OFF_CHK_LENGTH[13:2]: r = t.checker_remaining;
        default: r = 32'h0;
      endcase
    end
    return r;
  endfunction

  // watchdog: the random run needs about 800 cycles, limit at 20000
  initial begin
    #200000;
    num_errors++;
    report_and_stop;
  end

  // main sequence
  initial begin
    seed = 32'h0F28_5E17;
    clk = 1'h0;
    rstn = 1'h0;
    status = '0;
    ex = '0;
    num_errors = 0;
    total_checks = 0;
    offs = '{OFF_CORE_RESET, OFF_CORE_BUSY, OFF_ALERT_CODE, OFF_TIMEOUT,
      OFF_TX_RD_PTR, OFF_TX_WR_PTR, OFF_RX_RD_PTR, OFF_RX_WR_PTR,
      OFF_GEN_TYPE, OFF_GEN_LENGTH, OFF_CHK_MODE, OFF_CHK_LENGTH,
      OFF_HEADER_SKIP, 18'h001FC, 18'h000F0};
    repeat (16) @(posedge clk);
    #1;
    rstn = 1'h1;
    check(ctrl === ex, "control after reset");
    // random mix of reads, writes and offload probes
    repeat (300) begin
      a = offs[$unsigned($random(seed)) % 15];
      d = $random(seed);
      l = 4'($random(seed));
      // aliases through the upper word-address bits
      if (a != 18'h000F0 && ($random(seed) & 3) == 0) begin
        a = a | 18'h04000;
      end
      status = 112'({$random(seed), $random(seed), $random(seed),
                     $random(seed)});
      if (a == 18'h000F0) begin
        host.probe(a, s, g);
        check(s === 1'h1 && g === 1'h0, "offload access");
      end else if ($random(seed) & 1) begin
        host.wr(a, d, l);
        ex = apply(ex, a, d, l);
        got_c = ctrl;
        got_c.generator_start = 1'h0;
        got_c.checker_start = 1'h0;
        check(got_c === ex,
              "control after write");
        check(ctrl.generator_start === (a[13:2] == OFF_GEN_LENGTH[13:2]) &&
              ctrl.checker_start === (a[13:2] == OFF_CHK_LENGTH[13:2]),
              "start pulse");
      end else begin
        host.rd(a, d, lat);
        check(d === exp_rd(a, status),
              "read word");
        check(lat == READ_LATENCY, "read latency");
      end
    end
    host.probe(OFF_CORE_BUSY, s, g);
    check(s === 1'h0 && g === 1'h1, "core area access");
    report_and_stop;
  end
endmodule // tb
